// file: verilog/t1_line_maintenance_ctrl.sv
// Line maintenance, supervision and error counting register bank on classic Wishbone
// Functional notes
// - Remote and system remote loopbacks follow bits
// - Analog and digital loopback 2 follow bits
// - Loss declared after 175 low bits
// - Criterion one declares after 1544 low bits
// - Clear needs level, density, short zero runs
// - Clear threshold sits 4 dB above declare
// - Receive all ones during loss when enabled
// - Transmit all ones during loss when enabled
// - Each rising insert bit makes one violation
// - Zero limit 15 AMI, 7 B8ZS
// - FCC zero limit 80 AMI, 7 B8ZS
// - Count select 01 enables zero counting
// - Manual mode copies count on transfer rise
// - Auto mode copies count every second
// - Transfer ignored in auto; rearm each time
// - Transmit termination decode, 1xx reserved
// - Receive termination 1xx selects external circuit
// - Driver fail, loss flags gated by enables
// - Error flags gated by their enables
// - Counter overflow gated by its enable
// - Flags stay set until written one
// - Counter wrap sets overflow flag
`timescale 1ns/100ps
module t1_line_maintenance_ctrl
	import t1_maint_pkg::*;
#(
	parameter int REPORT_CYCLES = REPORT_PERIOD_CYCLES
)
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic wb_cyc,
	input wire logic wb_stb,
	input wire logic wb_we,
	input wire logic [7:0] wb_adr,
	input wire logic [3:0] wb_sel,
	input wire logic [31:0] wb_dat_w,
	output logic [31:0] wb_dat_r,
	output logic wb_ack,
	input wire logic bit_tick,
	input wire logic rx_data,
	input wire logic below_declare,
	input wire logic above_clear,
	input wire logic tx_data,
	input wire line_events_s line_events,
	output logic rx_data_out,
	output logic tx_data_out,
	output logic violation_pulse,
	output loop_ctrl_s loop_ctrl,
	output term_sel_s term_sel,
	output logic [4:0] los_threshold,
	output logic eq_on,
	output logic rx_power_down,
	output logic los_status,
	output logic irq
);

	typedef struct packed {
		logic [7:0] rx_cfg0;
		logic [7:0] rx_cfg1;
		logic [7:0] loop_reg;
		logic [7:0] supervision;
		logic [7:0] insert_count;
		logic [7:0] termination;
		logic [7:0] line_ie;
		logic [7:0] error_ie;
		logic [7:0] line_is;
		logic [7:0] error_is;
		logic [15:0] count_report;
		logic [15:0] zero_count;
		logic [6:0] zero_run;
		logic [31:0] sec_cnt;
		logic prev_insert;
		logic prev_transfer;
		logic prev_los;
		logic prev_df;
		logic ack;
		logic [7:0] dat_r;
		logic rx_out;
		logic tx_out;
		logic violation;
	} main_state_s;

	main_state_s s;
	main_state_s next_s;
	logic [1:0] rst_sync;
	logic rst_sync_n;
	logic los;
	logic [5:0] idx;
	logic req;
	logic wr;
	logic [7:0] wdata;
	logic [6:0] zero_limit;
	logic zero_event;
	logic [7:0] rd_mux;
	logic [7:0] line_w1c;
	logic [7:0] error_w1c;
	logic [7:0] line_set;
	logic [7:0] error_set;
	logic count_en;
	logic count_wrap;
	logic report_now;

	// Reset is released through two flip-flops
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync <= 2'b00;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_sync_n = rst_sync[1];

	signal_loss_detector u_los (
		.sys_clk(sys_clk),
		.rst_n(rst_sync_n),
		.bit_tick(bit_tick),
		.rx_mark(rx_data),
		.below_declare(below_declare),
		.above_clear(above_clear),
		.loss_criterion_sel(s.supervision[BIT_LOSS_CRITERION]),
		.los(los)
	);

	// Bus decode; a write lands at the edge where ack is seen high
	assign idx = wb_adr[7:2];
	assign req = wb_cyc & wb_stb;
	assign wr = req & wb_we & s.ack & wb_sel[0];
	assign wdata = wb_dat_w[7:0];

	// Zero run limit per line code and definition
	always_comb begin
		if (!s.rx_cfg0[BIT_AMI_SEL]) begin
			zero_limit = 7'(ZERO_LIMIT_B8ZS);
		end else if (s.insert_count[BIT_ZERO_RUN_DEF]) begin
			zero_limit = 7'(ZERO_LIMIT_AMI_FCC);
		end else begin
			zero_limit = 7'(ZERO_LIMIT_AMI_ANSI);
		end
	end

	// One event per run, on the first zero beyond the limit
	assign zero_event = bit_tick & ~rx_data & (s.zero_run == zero_limit);
	assign count_en = zero_event
		& (s.insert_count[POS_ERROR_COUNT_SEL +: 2] == COUNT_SEL_ZERO_RUN);
	assign count_wrap = count_en & (s.zero_count == 16'hffff);

	// Report trigger: transfer rise in manual mode, else the second tick
	assign report_now = s.insert_count[BIT_REPORT_MODE]
		? (s.sec_cnt == 32'(REPORT_CYCLES - 1))
		: (s.insert_count[BIT_COUNT_TRANSFER] & ~s.prev_transfer);

	// Sticky flag sources
	always_comb begin
		line_set = 8'h00;
		error_set = 8'h00;
		line_set[BIT_SIGNAL_MISSING] = los & ~s.prev_los;
		line_set[BIT_DRIVER_FAIL] = line_events.driver_fail & ~s.prev_df;
		error_set[BIT_TEMPLATE_OVERFLOW] = line_events.template_overflow;
		error_set[BIT_TX_FIFO_SLIP] = line_events.tx_fifo_slip;
		error_set[BIT_RX_FIFO_SLIP] = line_events.rx_fifo_slip;
		error_set[BIT_ZERO_RUN] = zero_event;
		error_set[BIT_CODE_VIOLATION] = line_events.code_violation;
		error_set[BIT_COUNTER_OVERFLOW] = count_wrap;
	end

	// Write-one-to-clear strobes
	assign line_w1c = (wr && idx == IDX_LINE_IRQ_STATUS) ? (wdata & MASK_LINE_IRQ) : 8'h00;
	assign error_w1c = (wr && idx == IDX_ERROR_IRQ_STATUS) ? (wdata & MASK_ERROR_IRQ) : 8'h00;

	// Read multiplexer; unmapped addresses read zero
	always_comb begin
		rd_mux = 8'h00;
		if (wb_adr[1:0] == 2'b00) begin
			unique case (idx)
				IDX_RX_CFG0: rd_mux = s.rx_cfg0;
				IDX_RX_CFG1: rd_mux = s.rx_cfg1;
				IDX_LOOP_CTRL: rd_mux = s.loop_reg;
				IDX_LINE_SUPERVISION_CTRL: rd_mux = s.supervision;
				IDX_ERROR_INSERT_COUNT_CTRL: rd_mux = s.insert_count;
				IDX_TERMINATION_SELECT: rd_mux = s.termination;
				IDX_LINE_IRQ_ENABLE: rd_mux = s.line_ie;
				IDX_ERROR_IRQ_ENABLE: rd_mux = s.error_ie;
				IDX_LINE_STATUS: begin
					rd_mux[BIT_SIGNAL_MISSING] = los;
					rd_mux[BIT_DRIVER_FAIL] = line_events.driver_fail;
				end
				IDX_LINE_IRQ_STATUS: rd_mux = s.line_is;
				IDX_ERROR_IRQ_STATUS: rd_mux = s.error_is;
				IDX_COUNT_LOW: rd_mux = s.count_report[7:0];
				IDX_COUNT_HIGH: rd_mux = s.count_report[15:8];
				default: rd_mux = 8'h00;
			endcase
		end
	end

	// Next state of the whole block
	always_comb begin
		next_s = s;
		// Bus slave: ack one cycle after the request, dropped the cycle after
		next_s.ack = req & ~s.ack;
		if (req & ~s.ack) begin
			next_s.dat_r = rd_mux;
		end
		if (wr && wb_adr[1:0] == 2'b00) begin
			unique case (idx)
				IDX_RX_CFG0: next_s.rx_cfg0 = wdata & MASK_RX_CFG0;
				IDX_RX_CFG1: next_s.rx_cfg1 = wdata & MASK_RX_CFG1;
				IDX_LOOP_CTRL: next_s.loop_reg = wdata & MASK_LOOP_CTRL;
				IDX_LINE_SUPERVISION_CTRL: next_s.supervision = wdata & MASK_SUPERVISION;
				IDX_ERROR_INSERT_COUNT_CTRL: next_s.insert_count = wdata & MASK_INSERT_COUNT;
				IDX_TERMINATION_SELECT: next_s.termination = wdata & MASK_TERMINATION;
				IDX_LINE_IRQ_ENABLE: next_s.line_ie = wdata & MASK_LINE_IRQ;
				IDX_ERROR_IRQ_ENABLE: next_s.error_ie = wdata & MASK_ERROR_IRQ;
				default: begin
				end
			endcase
		end
		// Sticky flags: a new event wins over a same-cycle clear
		next_s.line_is = (s.line_is & ~line_w1c) | line_set;
		next_s.error_is = (s.error_is & ~error_w1c) | error_set;
		next_s.prev_los = los;
		next_s.prev_df = line_events.driver_fail;
		// Zero run tracking on received bits
		if (bit_tick) begin
			next_s.zero_run = rx_data ? 7'h00
				: ((s.zero_run == 7'h7f) ? s.zero_run : s.zero_run + 7'h01);
		end
		// Internal counter and reporting; the count keeps running after a copy
		if (count_en) begin
			next_s.zero_count = s.zero_count + 16'h0001;
		end
		if (report_now) begin
			next_s.count_report = s.zero_count;
		end
		next_s.prev_transfer = s.insert_count[BIT_COUNT_TRANSFER];
		if (!s.insert_count[BIT_REPORT_MODE] || s.sec_cnt == 32'(REPORT_CYCLES - 1)) begin
			next_s.sec_cnt = 32'h0000_0000;
		end else begin
			next_s.sec_cnt = s.sec_cnt + 32'h0000_0001;
		end
		// Single violation per rising edge of the insert bit
		next_s.prev_insert = s.insert_count[BIT_VIOLATION_INSERT];
		next_s.violation = s.insert_count[BIT_VIOLATION_INSERT] & ~s.prev_insert;
		// All-ones insertion while loss is declared
		next_s.rx_out = (s.supervision[BIT_RX_ALL_ONES] & los) | rx_data;
		next_s.tx_out = (s.supervision[BIT_TX_ALL_ONES] & los) | tx_data;
	end

	// Block state register
	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			s <= '{rx_cfg0: RST_RX_CFG0, rx_cfg1: RST_RX_CFG1, loop_reg: RST_ZERO,
				supervision: RST_ZERO, insert_count: RST_ZERO,
				termination: RST_TERMINATION, line_ie: RST_ZERO, error_ie: RST_ZERO,
				line_is: RST_ZERO, error_is: RST_ZERO, count_report: 16'h0000,
				zero_count: 16'h0000, zero_run: 7'h00, sec_cnt: 32'h0000_0000,
				prev_insert: 1'b0, prev_transfer: 1'b0, prev_los: 1'b0, prev_df: 1'b0,
				ack: 1'b0, dat_r: 8'h00, rx_out: 1'b0, tx_out: 1'b0, violation: 1'b0};
		end else begin
			s <= next_s;
		end
	end

	// Loopback enables
	assign loop_ctrl.system_remote_loop_en = s.loop_reg[BIT_SYSTEM_REMOTE_LOOP];
	assign loop_ctrl.remote_loop_en = s.loop_reg[BIT_REMOTE_LOOP];
	assign loop_ctrl.analog_loop_en = s.loop_reg[BIT_ANALOG_LOOP];
	assign loop_ctrl.local_digital_loop2_en = s.loop_reg[BIT_LOCAL_DIGITAL_LOOP2];
	assign loop_ctrl.system_local_loop_en = s.loop_reg[BIT_SYSTEM_LOCAL_LOOP];
	assign loop_ctrl.local_digital_loop1_en = s.loop_reg[BIT_LOCAL_DIGITAL_LOOP1];

	// Termination decode to one-hot match selects
	always_comb begin
		logic [2:0] tcode;
		logic [2:0] rcode;
		tcode = s.termination[POS_TX_TERM +: 3];
		rcode = s.termination[POS_RX_TERM +: 3];
		term_sel.tx_match = tcode[2] ? 4'h0 : (4'h1 << tcode[1:0]);
		term_sel.rx_match = rcode[2] ? 4'h0 : (4'h1 << rcode[1:0]);
		term_sel.rx_external = rcode[2];
	end

	// Interrupt: OR of every enabled sticky flag
	assign irq = |(s.line_is & s.line_ie)
		| |(s.error_is & s.error_ie);

	assign wb_ack = s.ack;
	assign wb_dat_r = {24'h00_0000, s.dat_r};
	assign rx_data_out = s.rx_out;
	assign tx_data_out = s.tx_out;
	assign violation_pulse = s.violation;
	assign los_threshold = s.rx_cfg1[POS_LOS_THRESHOLD +: 5];
	assign eq_on = s.rx_cfg1[BIT_EQ_ON];
	assign rx_power_down = s.rx_cfg0[BIT_RX_OFF];
	assign los_status = los;

endmodule : t1_line_maintenance_ctrl

// file: inc/t1_maint_pkg.sv
// Shared constants, register map and carrier types of the line maintenance block
package t1_maint_pkg;

	// Register indices; byte address is four times the index
	localparam logic [5:0] IDX_RX_CFG0 = 6'h28;
	localparam logic [5:0] IDX_RX_CFG1 = 6'h29;
	localparam logic [5:0] IDX_LOOP_CTRL = 6'h2b;
	localparam logic [5:0] IDX_LINE_SUPERVISION_CTRL = 6'h2c;
	localparam logic [5:0] IDX_ERROR_INSERT_COUNT_CTRL = 6'h31;
	localparam logic [5:0] IDX_TERMINATION_SELECT = 6'h32;
	localparam logic [5:0] IDX_LINE_IRQ_ENABLE = 6'h33;
	localparam logic [5:0] IDX_ERROR_IRQ_ENABLE = 6'h34;
	localparam logic [5:0] IDX_LINE_STATUS = 6'h36;
	localparam logic [5:0] IDX_LINE_IRQ_STATUS = 6'h3a;
	localparam logic [5:0] IDX_ERROR_IRQ_STATUS = 6'h3b;
	localparam logic [5:0] IDX_COUNT_LOW = 6'h3c;
	localparam logic [5:0] IDX_COUNT_HIGH = 6'h3d;

	// Writable bits of each register
	localparam logic [7:0] MASK_RX_CFG0 = 8'h11;
	localparam logic [7:0] MASK_RX_CFG1 = 8'h5f;
	localparam logic [7:0] MASK_LOOP_CTRL = 8'h77;
	localparam logic [7:0] MASK_SUPERVISION = 8'h1c;
	localparam logic [7:0] MASK_INSERT_COUNT = 8'h5f;
	localparam logic [7:0] MASK_TERMINATION = 8'h3f;
	localparam logic [7:0] MASK_LINE_IRQ = 8'h05;
	localparam logic [7:0] MASK_ERROR_IRQ = 8'h77;

	// Reset values
	localparam logic [7:0] RST_RX_CFG0 = 8'h00;
	localparam logic [7:0] RST_RX_CFG1 = 8'h15;
	localparam logic [7:0] RST_TERMINATION = 8'h07;
	localparam logic [7:0] RST_ZERO = 8'h00;

	// Field positions
	localparam int BIT_AMI_SEL = 0;
	localparam int BIT_RX_OFF = 4;
	localparam int BIT_EQ_ON = 6;
	localparam int POS_LOS_THRESHOLD = 0;
	localparam int BIT_LOCAL_DIGITAL_LOOP2 = 0;
	localparam int BIT_ANALOG_LOOP = 1;
	localparam int BIT_REMOTE_LOOP = 2;
	localparam int BIT_SYSTEM_REMOTE_LOOP = 4;
	localparam int BIT_SYSTEM_LOCAL_LOOP = 5;
	localparam int BIT_LOCAL_DIGITAL_LOOP1 = 6;
	localparam int BIT_TX_ALL_ONES = 2;
	localparam int BIT_RX_ALL_ONES = 3;
	localparam int BIT_LOSS_CRITERION = 4;
	localparam int BIT_COUNT_TRANSFER = 0;
	localparam int BIT_REPORT_MODE = 1;
	localparam int POS_ERROR_COUNT_SEL = 2;
	localparam int BIT_ZERO_RUN_DEF = 4;
	localparam int BIT_VIOLATION_INSERT = 6;
	localparam int POS_RX_TERM = 0;
	localparam int POS_TX_TERM = 3;
	localparam int BIT_SIGNAL_MISSING = 0;
	localparam int BIT_DRIVER_FAIL = 2;
	localparam int BIT_COUNTER_OVERFLOW = 0;
	localparam int BIT_CODE_VIOLATION = 1;
	localparam int BIT_ZERO_RUN = 2;
	localparam int BIT_RX_FIFO_SLIP = 4;
	localparam int BIT_TX_FIFO_SLIP = 5;
	localparam int BIT_TEMPLATE_OVERFLOW = 6;

	// Codes
	localparam logic [1:0] COUNT_SEL_ZERO_RUN = 2'b01;

	// Supervision counts in bit intervals
	localparam int LOS_DECLARE_SHORT_BITS = 175;
	localparam int LOS_DECLARE_LONG_BITS = 1544;
	localparam int LOS_CLEAR_WINDOW_BITS = 128;
	localparam int LOS_MIN_DENSITY_PCT10 = 125;
	localparam int LOS_MIN_MARKS = (LOS_CLEAR_WINDOW_BITS * LOS_MIN_DENSITY_PCT10 + 999) / 1000;
	localparam int LOS_ZERO_RUN_LIMIT = 100;
	localparam int ZERO_LIMIT_AMI_ANSI = 15;
	localparam int ZERO_LIMIT_AMI_FCC = 80;
	localparam int ZERO_LIMIT_B8ZS = 7;

	// Auto report period
	localparam int CLK_PERIOD_NS = 25;
	localparam int REPORT_PERIOD_MS = 1000;
	localparam int REPORT_PERIOD_CYCLES = REPORT_PERIOD_MS * 1000000 / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		LOS_CLEAR = 2'b01,
		LOS_DECLARED = 2'b10
	} los_state_e;

	typedef struct packed {
		logic driver_fail;
		logic template_overflow;
		logic tx_fifo_slip;
		logic rx_fifo_slip;
		logic code_violation;
	} line_events_s;

	typedef struct packed {
		logic system_remote_loop_en;
		logic remote_loop_en;
		logic analog_loop_en;
		logic local_digital_loop2_en;
		logic system_local_loop_en;
		logic local_digital_loop1_en;
	} loop_ctrl_s;

	typedef struct packed {
		logic [3:0] tx_match;
		logic [3:0] rx_match;
		logic rx_external;
	} term_sel_s;

	typedef struct packed {
		los_state_e st;
		logic [10:0] low_run;
		logic [6:0] win;
		logic [7:0] marks;
		logic [6:0] zrun;
		logic bad;
	} los_state_s;

endpackage : t1_maint_pkg

// file: verilog/signal_loss_detector.sv
// Loss-of-signal declare and clear supervision over received bit intervals
`timescale 1ns/100ps
module signal_loss_detector
	import t1_maint_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic bit_tick,
	input wire logic rx_mark,
	input wire logic below_declare,
	input wire logic above_clear,
	input wire logic loss_criterion_sel,
	output logic los
);

	los_state_s s;
	los_state_s next_s;
	logic [10:0] declare_limit;
	logic [7:0] next_marks;
	logic [6:0] next_zrun;

	// Declare length follows the selected criterion
	assign declare_limit = loss_criterion_sel ? 11'(LOS_DECLARE_LONG_BITS)
		: 11'(LOS_DECLARE_SHORT_BITS);

	// One step per received bit interval
	always_comb begin
		next_s = s;
		next_marks = s.marks + 8'(rx_mark);
		next_zrun = rx_mark ? 7'h00 : ((s.zrun == 7'h7f) ? s.zrun : s.zrun + 7'h01);
		if (bit_tick) begin
			unique case (s.st)
				LOS_CLEAR: begin
					if (below_declare) begin
						if (s.low_run + 11'h001 >= declare_limit) begin
							next_s.st = LOS_DECLARED;
							next_s.win = 7'h00;
							next_s.marks = 8'h00;
							next_s.zrun = 7'h00;
							next_s.bad = 1'b0;
						end else begin
							next_s.low_run = s.low_run + 11'h001;
						end
					end else begin
						next_s.low_run = 11'h000;
					end
				end
				LOS_DECLARED: begin
					next_s.win = s.win + 7'h01;
					next_s.marks = next_marks;
					next_s.zrun = next_zrun;
					// Level must exceed the raised clear threshold throughout
					next_s.bad = s.bad | ~above_clear
						| (next_zrun >= 7'(LOS_ZERO_RUN_LIMIT));
					if (s.win == 7'(LOS_CLEAR_WINDOW_BITS - 1)) begin
						if (!next_s.bad && next_marks >= 8'(LOS_MIN_MARKS)) begin
							next_s.st = LOS_CLEAR;
							next_s.low_run = 11'h000;
						end
						next_s.win = 7'h00;
						next_s.marks = 8'h00;
						next_s.bad = 1'b0;
					end
				end
				default: begin
					next_s.st = LOS_CLEAR;
				end
			endcase
		end
	end

	// State register
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '{st: LOS_CLEAR, low_run: 11'h000, win: 7'h00, marks: 8'h00,
				zrun: 7'h00, bad: 1'b0};
		end else begin
			s <= next_s;
		end
	end

	assign los = (s.st == LOS_DECLARED);

endmodule : signal_loss_detector

// file: dv/t1_maint_properties.sv
// Port-level properties of the line maintenance block
`timescale 1ns/100ps
module t1_maint_properties
	import t1_maint_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic wb_cyc,
	input wire logic wb_stb,
	input wire logic wb_we,
	input wire logic [31:0] wb_dat_r,
	input wire logic wb_ack,
	input wire logic bit_tick,
	input wire logic rx_data,
	input wire logic below_declare,
	input wire logic above_clear,
	input wire logic tx_data,
	input wire logic rx_data_out,
	input wire logic tx_data_out,
	input wire logic violation_pulse,
	input wire loop_ctrl_s loop_ctrl,
	input wire term_sel_s term_sel,
	input wire logic los_status,
	input wire logic irq
);
	typedef struct packed {
		logic [1:0] up;
		logic [10:0] low;
		logic [7:0] clr;
	} chk_s;
	chk_s s;
	chk_s next_s;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// Edges since release, runs of low and of adequate bit intervals
	always_comb begin
		next_s = s;
		if (s.up != 2'h3) next_s.up = s.up + 2'h1;
		if (bit_tick) begin
			next_s.low = below_declare ? s.low + {10'h0, ~&s.low} : 11'h000;
			next_s.clr = above_clear ? s.clr + {7'h0, ~&s.clr} : 8'h00;
		end
	end
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) s <= '0;
		else s <= next_s;
	end
	a_ack_single: assert property (wb_ack |=> !wb_ack)
		else $error("ack held longer than one cycle");
	a_ack_needs_req: assert property (wb_ack |-> $past(wb_cyc && wb_stb) && wb_dat_r[31:8] == 24'h0)
		else $error("ack without request or upper data set");
	a_rx_clean_pass: assert property (s.up == 2'h3 && $past(!los_status) |-> rx_data_out == $past(rx_data))
		else $error("receive data altered without loss");
	a_tx_clean_pass: assert property (s.up == 2'h3 && $past(!los_status) |-> tx_data_out == $past(tx_data))
		else $error("transmit data altered without loss");
	a_violation_once: assert property (violation_pulse |=> !violation_pulse)
		else $error("violation pulse longer than one cycle");
	a_loss_declare_run: assert property ($rose(los_status) |-> s.low >= LOS_DECLARE_SHORT_BITS)
		else $error("loss declared before enough low intervals");
	a_loss_clear_run: assert property ($fell(los_status) |-> s.clr >= LOS_CLEAR_WINDOW_BITS)
		else $error("loss cleared before a full adequate window");
	a_rx_term_decode: assert property (term_sel.rx_external ? term_sel.rx_match == 4'h0 : $onehot(term_sel.rx_match))
		else $error("receive termination decode wrong");
	a_tx_term_decode: assert property ($onehot0(term_sel.tx_match))
		else $error("transmit termination decode wrong");
	a_irq_fall_write: assert property ($fell(irq) |-> $past(wb_ack && wb_we))
		else $error("interrupt dropped without a write");
	a_loop_from_write: assert property (!$stable(loop_ctrl) |-> $past(wb_ack && wb_we))
		else $error("loopback enables changed without a write");
	c_loss: cover property ($rose(los_status));
	c_violation: cover property (violation_pulse);
	c_irq_clear: cover property ($fell(irq));
endmodule : t1_maint_properties

// file: dv/line_partner.sv
// Far-end line model: bit interval strobe, received marks and level detectors
`timescale 1ns/100ps
module line_partner
	import t1_maint_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic lost,
	input wire logic [6:0] gap,
	output logic bit_tick,
	output logic rx_data,
	output logic below_declare,
	output logic above_clear
);
	typedef struct packed {
		logic [1:0] div;
		logic [6:0] zeros;
		logic tick;
		logic mark;
		logic low;
	} line_s;
	line_s s;
	line_s next_s;
	// One interval per four clocks; a mark closes each run of gap zeros
	always_comb begin
		next_s = s;
		next_s.div = s.div + 2'h1;
		next_s.tick = s.div == 2'h3;
		if (s.div == 2'h3) begin
			next_s.low = lost;
			next_s.mark = !lost && s.zeros >= gap;
			next_s.zeros = next_s.mark ? 7'h00 : s.zeros + {6'h0, ~&s.zeros};
		end
	end
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) s <= '0;
		else s <= next_s;
	end
	// Data is only valid on the strobe; between strobes it shows the inverse
	assign bit_tick = s.tick;
	assign rx_data = s.tick ? s.mark : ~s.mark;
	assign below_declare = s.low;
	assign above_clear = !s.low;
endmodule : line_partner

// file: dv/testbench.sv
// Self-checking bench for the line maintenance block
`timescale 1ns/100ps
module testbench
	import t1_maint_pkg::*;
;
	localparam int RPT = 50;
	logic sys_clk = 1'b0, rst_n = 1'b0, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
	logic tx_data = 1'b0, lost = 1'b0, cnt_on = 1'b0;
	logic [7:0] wb_adr = 8'h00;
	logic [3:0] wb_sel = 4'h0, sel_v = 4'h1;
	logic [31:0] wb_dat_w = 32'h0, wb_dat_r, rd;
	logic wb_ack, bit_tick, rx_data, below_declare, above_clear;
	logic rx_data_out, tx_data_out, violation_pulse, los_status, irq;
	logic [4:0] los_threshold;
	logic eq_on, rx_power_down;
	logic [6:0] gap = 7'h01;
	line_events_s line_events = '0;
	loop_ctrl_s loop_ctrl;
	term_sel_s term_sel;
	int fails = 0, n_checks = 0, exz = 0, zr = 0, lim = 7, lowt = 0, hit = 0, pulses = 0;
	logic [5:0] ix [5] = '{6'h2c, 6'h31, 6'h32, 6'h33, 6'h34};
	logic [7:0] mk [5] = '{8'h1c, 8'h5f, 8'h3f, 8'h05, 8'h77};
	logic [7:0] lb [6] = '{8'h10, 8'h04, 8'h02, 8'h01, 8'h20, 8'h40};
	logic [7:0] eb [4] = '{8'h40, 8'h20, 8'h10, 8'h02};
	int lm [3] = '{7, 15, 80};
	always #12.5 sys_clk = ~sys_clk;
	t1_line_maintenance_ctrl #(.REPORT_CYCLES(RPT)) t1_line_maintenance_ctrl_i (
		.sys_clk, .rst_n, .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_sel, .wb_dat_w, .wb_dat_r,
		.wb_ack, .bit_tick, .rx_data, .below_declare, .above_clear, .tx_data, .line_events,
		.rx_data_out, .tx_data_out, .violation_pulse, .loop_ctrl, .term_sel, .los_threshold,
		.eq_on, .rx_power_down, .los_status, .irq);
	line_partner line_partner_i (.sys_clk, .rst_n, .lost, .gap, .bit_tick, .rx_data,
		.below_declare, .above_clear);
	// Expected zero-run events, low and adequate interval runs, pulse count
	always @(posedge sys_clk) begin
		if (bit_tick === 1'b1) begin
			zr <= rx_data === 1'b1 ? 0 : zr + 1;
			if (rx_data === 1'b0 && zr == lim && cnt_on) exz <= exz + 1;
			lowt <= below_declare === 1'b1 ? lowt + 1 : 0;
			hit <= above_clear === 1'b1 ? hit + 1 : 0;
		end
		if (violation_pulse === 1'b1) pulses <= pulses + 1;
		// Transmit data toggles so that pass-through and insertion differ
		tx_data <= ~tx_data;
	end
	task automatic complete_run;
		if (fails == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : complete_run
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Ends the run as failed once a bounded wait has used all 8000 cycles
	task automatic bail(input int n);
		if (n >= 8000) begin
			fails++;
			complete_run();
		end
	endtask : bail
	task automatic bus(input logic we, input logic [5:0] idx, input logic [7:0] d);
		int n;
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= {idx, 2'b00};
		wb_sel <= sel_v;
		wb_dat_w <= {24'h0, d};
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (wb_ack !== 1'b1 && n < 8000);
		bail(n);
		rd = wb_dat_r;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge sys_clk);
	endtask : bus
	task automatic wr(input logic [5:0] idx, input logic [7:0] d);
		bus(1'b1, idx, d);
	endtask : wr
	task automatic rc(input logic [5:0] idx, input logic [7:0] e);
		bus(1'b0, idx, 8'h00);
		chk(rd, {24'h0, e});
	endtask : rc
	task automatic wait_los(input logic v);
		int n;
		n = 0;
		while (los_status !== v && n < 8000) begin
			@(posedge sys_clk);
			n++;
		end
		bail(n);
	endtask : wait_los
	initial begin
		logic [3:0] m;
		logic [3:0] n1;
		logic [3:0] n2;
		int p0;
		repeat (16) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		chk(32'(term_sel), 32'h21);
		chk(32'(los_threshold), 32'h15);
		for (int i = 0; i < 5; i++) rc(ix[i], i == 2 ? RST_TERMINATION : RST_ZERO);
		rc(6'h3f, 8'h00);
		// Writable bits of the five registers in ix, then back to zero
		for (int i = 0; i < 5; i++) begin
			wr(ix[i], 8'hff);
			rc(ix[i], mk[i]);
			wr(ix[i], 8'h00);
		end
		sel_v = 4'h0;
		wr(IDX_LINE_IRQ_ENABLE, 8'h05);
		sel_v = 4'h1;
		rc(IDX_LINE_IRQ_ENABLE, 8'h00);
		for (int i = 0; i < 6; i++) begin
			wr(IDX_LOOP_CTRL, lb[i]);
			chk(32'(loop_ctrl), 32'(6'h20 >> i));
		end
		for (int c = 0; c < 8; c++) begin
			m = c < 4 ? 4'h1 << c : 4'h0;
			wr(IDX_TERMINATION_SELECT, 8'(c * 9));
			chk(32'(term_sel), 32'({m, m, c > 3}));
		end
		wr(IDX_RX_CFG1, 8'hff);
		chk(32'({eq_on, los_threshold}), 32'h3f);
		wr(IDX_RX_CFG0, 8'h10);
		chk(32'(rx_power_down), 32'h1);
		// Loss declare, all-ones insertion per enable, flag and clear
		wr(IDX_LINE_IRQ_ENABLE, 8'h01);
		lost <= 1'b1;
		wait_los(1'b1);
		chk(lowt, LOS_DECLARE_SHORT_BITS);
		@(posedge sys_clk);
		chk(32'(irq), 32'h1);
		rc(IDX_LINE_STATUS, 8'h01);
		for (int i = 0; i < 4; i++) begin
			wr(IDX_LINE_SUPERVISION_CTRL, 8'(i << 2));
			n1 = 4'h0;
			n2 = 4'h0;
			repeat (8) begin
				@(posedge sys_clk);
				n1 += {3'h0, rx_data_out};
				n2 += {3'h0, tx_data_out};
			end
			chk(32'(n1 == 4'h8), 32'(i > 1));
			chk(32'(n2), i % 2 ? 32'h8 : 32'h4);
		end
		rc(IDX_LINE_IRQ_STATUS, 8'h01);
		wr(IDX_LINE_IRQ_STATUS, 8'h01);
		chk(32'(irq), 32'h0);
		lost <= 1'b0;
		wait_los(1'b0);
		chk(32'(hit >= 128 && hit < 256), 32'h1);
		wr(IDX_LINE_SUPERVISION_CTRL, 8'h10);
		lost <= 1'b1;
		wait_los(1'b1);
		chk(lowt, LOS_DECLARE_LONG_BITS);
		lost <= 1'b0;
		wait_los(1'b0);
		wr(IDX_LINE_IRQ_STATUS, 8'h05);
		wr(IDX_LINE_IRQ_ENABLE, 8'h00);
		// One violation per rising insert bit only
		p0 = pulses;
		wr(IDX_ERROR_INSERT_COUNT_CTRL, 8'h40);
		wr(IDX_ERROR_INSERT_COUNT_CTRL, 8'h40);
		wr(IDX_ERROR_INSERT_COUNT_CTRL, 8'h00);
		wr(IDX_ERROR_INSERT_COUNT_CTRL, 8'h40);
		repeat (4) @(posedge sys_clk);
		chk(pulses - p0, 2);
		// Zero-run limits per line code and definition, manual reports
		wr(IDX_ERROR_IRQ_STATUS, 8'h77);
		for (int k = 0; k < 3; k++) begin
			wr(IDX_RX_CFG0, {7'h0, k > 0});
			wr(IDX_ERROR_INSERT_COUNT_CTRL, {3'h0, k > 1, 4'h4});
			lim = lm[k];
			cnt_on = 1'b1;
			gap <= 7'(lim);
			repeat (8 * lim + 40) @(posedge sys_clk);
			gap <= 7'(lim + 1);
			repeat (8 * lim + 40) @(posedge sys_clk);
			gap <= 7'h01;
			repeat (20) @(posedge sys_clk);
			wr(IDX_ERROR_INSERT_COUNT_CTRL, {3'h0, k > 1, 4'h5});
			rc(IDX_COUNT_LOW, 8'(exz));
			rc(IDX_COUNT_HIGH, 8'(exz >> 8));
			rc(IDX_ERROR_IRQ_STATUS, 8'h04);
			wr(IDX_ERROR_IRQ_STATUS, 8'h04);
		end
		p0 = exz;
		gap <= 7'd90;
		repeat (800) @(posedge sys_clk);
		gap <= 7'h01;
		repeat (20) @(posedge sys_clk);
		rc(IDX_COUNT_LOW, 8'(p0));
		wr(IDX_ERROR_INSERT_COUNT_CTRL, 8'h17);
		repeat (2 * RPT) @(posedge sys_clk);
		rc(IDX_COUNT_LOW, 8'(exz));
		wr(IDX_ERROR_IRQ_STATUS, 8'h77);
		// Each of four error event flags reaches the interrupt only through its enable; driver fail once enabled
		for (int i = 0; i < 4; i++) begin
			line_events <= 5'(8 >> i);
			@(posedge sys_clk);
			line_events <= '0;
			repeat (2) @(posedge sys_clk);
			chk(32'(irq), 32'h0);
			wr(IDX_ERROR_IRQ_ENABLE, eb[i]);
			chk(32'(irq), 32'h1);
			rc(IDX_ERROR_IRQ_STATUS, eb[i]);
			wr(IDX_ERROR_IRQ_STATUS, eb[i]);
			chk(32'(irq), 32'h0);
			wr(IDX_ERROR_IRQ_ENABLE, 8'h00);
		end
		line_events <= 5'h10;
		repeat (2) @(posedge sys_clk);
		wr(IDX_LINE_IRQ_ENABLE, 8'h04);
		chk(32'(irq), 32'h1);
		rc(IDX_LINE_STATUS, 8'h04);
		line_events <= '0;
		wr(IDX_LINE_IRQ_STATUS, 8'h04);
		chk(32'(irq), 32'h0);
		complete_run();
	end
endmodule : testbench
bind t1_line_maintenance_ctrl t1_maint_properties t1_maint_properties_i (.sys_clk, .rst_n,
	.wb_cyc, .wb_stb, .wb_we, .wb_dat_r, .wb_ack, .bit_tick, .rx_data, .below_declare,
	.above_clear, .tx_data, .rx_data_out, .tx_data_out, .violation_pulse, .loop_ctrl,
	.term_sel, .los_status, .irq);
